/* File: rtl/sync_regs_consts.svh */
// Constants of the synchronizer register bank: offsets, reset values and serial framing.
// Assumes 8-bit registers on a 7-bit register address carried by the serial port.
`ifndef SYNC_REGS_CONSTS_SVH
`define SYNC_REGS_CONSTS_SVH

// Register offsets
`define ADDR_CHIP_IDENTITY_WORD    7'h00
`define ADDR_PIN_CONTROL_SELECT    7'h01
`define ADDR_INPUT_FAIL_IRQ_STATUS 7'h02
`define ADDR_LOOP_IRQ_STATUS       7'h03
`define ADDR_RSVD_04               7'h04
`define ADDR_MON_FAULT_FLAGS_A     7'h05
`define ADDR_MON_FAULT_FLAGS_B     7'h06
`define ADDR_RSVD_07               7'h07
`define ADDR_RSVD_08               7'h08
`define ADDR_INPUT_FAIL_IRQ_MASK   7'h09
`define ADDR_LOOP_IRQ_MASK         7'h0a
`define ADDR_RSVD_0B               7'h0b
`define ADDR_MON_FAULT_MASK_A      7'h0c
`define ADDR_MON_FAULT_MASK_B      7'h0d
`define ADDR_RSVD_0E               7'h0e
`define ADDR_RSVD_0F               7'h0f
`define ADDR_MEAS_FREQ_CODE_A      7'h10
`define ADDR_MEAS_FREQ_CODE_B      7'h11
`define ADDR_RSVD_12               7'h12
`define ADDR_RSVD_13               7'h13

// Reset values
`define RST_PIN_CONTROL_SELECT     8'h00
`define RST_INPUT_FAIL_IRQ_STATUS  8'hff
`define RST_LOOP_IRQ_STATUS        8'h70
`define RST_MON_FAULT_FLAGS        8'hff
`define RST_IRQ_MASK               8'h00
`define RST_MON_FAULT_MASK         8'hff
`define RST_MEAS_FREQ_CODE         8'hff
`define RST_NIBBLE                 4'hf
`define READ_AS_ZERO               8'h00
`define READ_AS_ZERO_5             5'h00
`define UPPER_NIBBLE_ONES          4'hf

// Serial framing: command byte is read flag in bit 7 and address in bits 6:0, then one data byte
`define CMD_LAST_BIT               4'h7
`define DATA_LAST_BIT              4'hf
`define BIT_CNT_ZERO               4'h0
`define BIT_CNT_ONE                4'h1
`define BYTE_ZERO                  8'h00
`define DATA_PHASE_BIT             3

`endif

/* File: rtl/sync_regs_pkg.sv */
// Types shared by the synchronizer register bank and its serial port.
// Assumes the constants header is included by the design files that need numbers.
`default_nettype none

package sync_regs_pkg;

	// Serial port pins seen by the device
	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic mosi;
	} spi_in_s;

	// Register access request from the serial port
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] data;
	} reg_req_s;

	// One 4-bit field per reference input
	typedef struct packed {
		logic [3:0] input_clock_two;
		logic [3:0] input_clock_one;
		logic [3:0] input_clock_zero;
	} ref_nibbles_s;

endpackage

`default_nettype wire

/* File: rtl/spi_serial_port.sv */
// Serial port slave: mode 0, chip select low, command byte then one data byte.
// Assumes the pins are synchronous to clk and each half period of sclk spans at least three clk cycles.
`include "sync_regs_consts.svh"
`default_nettype none

module spi_serial_port (
	// Clock, reset, enable
	input  wire logic                    clk,
	input  wire logic                    reset,
	input  wire logic                    ce,
	// Serial pins
	input  wire sync_regs_pkg::spi_in_s  spi_in,
	output logic                         miso,
	output logic                         miso_oe,
	// Register access
	output var  sync_regs_pkg::reg_req_s req,
	output logic                         wr_stb,
	output logic                         rd_stb,
	input  wire logic [7:0]              rd_data,
	input  wire logic                    rd_valid
);

	logic       sclk_prev_q;
	logic [3:0] bit_cnt_q;
	logic [6:0] shift_q;
	logic       is_read_q;
	logic [7:0] tx_q;
	logic       miso_q;
	logic       rise;
	logic       fall;

	////////////////////////////////////////////////////////////////////////
	// Edge detection of the serial clock inside a frame
	assign rise = spi_in.sclk & ~sclk_prev_q & ~spi_in.cs_n;
	assign fall = ~spi_in.sclk & sclk_prev_q & ~spi_in.cs_n;

	always_ff @(posedge clk) begin
		if (reset) begin
			sclk_prev_q <= 1'b0;
		end else if (ce) begin
			sclk_prev_q <= spi_in.sclk;
		end
	end

	// Bit counter, restarts when chip select goes high
	always_ff @(posedge clk) begin
		if (reset) begin
			bit_cnt_q <= `BIT_CNT_ZERO;
		end else if (ce) begin
			if (spi_in.cs_n) begin
				bit_cnt_q <= `BIT_CNT_ZERO;
			end else if (rise) begin
				bit_cnt_q <= bit_cnt_q + `BIT_CNT_ONE;
			end
		end
	end

	// Input shift register, msb first
	always_ff @(posedge clk) begin
		if (reset) begin
			shift_q <= 7'h00;
		end else if (ce && rise) begin
			shift_q <= {shift_q[5:0], spi_in.mosi};
		end
	end

	// Command capture and access strobes
	always_ff @(posedge clk) begin
		if (reset) begin
			is_read_q <= 1'b0;
			req       <= '0;
			rd_stb    <= 1'b0;
			wr_stb    <= 1'b0;
		end else if (ce) begin
			rd_stb <= 1'b0;
			wr_stb <= 1'b0;
			if (spi_in.cs_n) begin
				is_read_q <= 1'b0;
			end else if (rise && bit_cnt_q == `CMD_LAST_BIT) begin
				is_read_q <= shift_q[6];
				req.addr  <= {shift_q[5:0], spi_in.mosi};
				rd_stb    <= shift_q[6];
			end else if (rise && bit_cnt_q == `DATA_LAST_BIT && !is_read_q) begin
				req.data <= {shift_q[6:0], spi_in.mosi};
				wr_stb   <= 1'b1;
			end
		end
	end

	// Read data shifted out on falling edges of the data byte
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_q   <= `BYTE_ZERO;
			miso_q <= 1'b0;
		end else if (ce) begin
			if (spi_in.cs_n) begin
				miso_q <= 1'b0;
			end else if (rd_valid) begin
				tx_q <= rd_data;
			end else if (fall && is_read_q && bit_cnt_q[`DATA_PHASE_BIT]) begin
				miso_q <= tx_q[7];
				tx_q   <= {tx_q[6:0], 1'b0};
			end
		end
	end

	assign miso    = miso_q;
	assign miso_oe = ~spi_in.cs_n; // Driven only while selected

	// Output is released whenever the frame is closed
	property p_miso_release;
		@(posedge clk) disable iff (reset)
		spi_in.cs_n |-> !miso_oe;
	endproperty
	a_miso_release: assert property (p_miso_release) else $error("miso driven while deselected");

	// Data line returns low once the frame is closed
	property p_miso_idle;
		@(posedge clk) disable iff (reset)
		ce && spi_in.cs_n |=> !miso;
	endproperty
	a_miso_idle: assert property (p_miso_idle) else $error("miso not cleared after frame");

endmodule

`default_nettype wire

/* File: rtl/sync_misc_irq_monitor_regs.sv */
// Register bank 0x00 to 0x13 of a line-card clock synchronizer: identity, pin control, interrupts,
// monitor fault flags and detected frequency codes, reached over the serial port.
// Assumes monitor, frequency detector and loop inputs are synchronous to clk.
`include "sync_regs_consts.svh"
`default_nettype none

module sync_misc_irq_monitor_regs #(
	parameter logic [6:0] CHIP_IDENTITY = 7'h2b // Arbitrary value
) (
	// Clock, reset, enable
	input  wire logic                        clk,
	input  wire logic                        reset,
	input  wire logic                        ce,
	// Serial port
	input  wire sync_regs_pkg::spi_in_s      spi_in,
	output logic                             miso,
	output logic                             miso_oe,
	// Monitor and loop status from the device
	input  wire sync_regs_pkg::ref_nibbles_s mon_fail,
	input  wire sync_regs_pkg::ref_nibbles_s freq_code,
	input  wire logic [7:0]                  loop_event,
	// Control and interrupt outputs
	output logic [7:0]                       pin_control,
	output logic                             irq_n
);

	sync_regs_pkg::reg_req_s     req;
	logic                        wr_stb;
	logic                        rd_stb;
	logic [7:0]                  rd_mux;
	logic [7:0]                  rd_data_q;
	logic                        rd_valid_q;
	logic                        ready_q;
	logic [7:0]                  pin_ctrl_q;
	logic [7:0]                  in_fail_isr_q;
	logic [7:0]                  loop_isr_q;
	logic [7:0]                  in_fail_mask_q;
	logic [7:0]                  loop_mask_q;
	logic [7:0]                  mon_mask_a_q;
	logic [7:0]                  mon_mask_b_q;
	sync_regs_pkg::ref_nibbles_s mon_flags_q;
	sync_regs_pkg::ref_nibbles_s mon_mask;
	sync_regs_pkg::ref_nibbles_s freq_q;
	logic [11:0]                 mon_clr;
	logic                        loop_clr;
	logic [2:0]                  ref_any_fail;
	logic                        irq_q;

	////////////////////////////////////////////////////////////////////////
	// Serial port
	spi_serial_port u_port (
		.clk      (clk),
		.reset    (reset),
		.ce       (ce),
		.spi_in   (spi_in),
		.miso     (miso),
		.miso_oe  (miso_oe),
		.req      (req),
		.wr_stb   (wr_stb),
		.rd_stb   (rd_stb),
		.rd_data  (rd_data_q),
		.rd_valid (rd_valid_q)
	);

	////////////////////////////////////////////////////////////////////////
	// Ready indication, set one cycle after reset release
	always_ff @(posedge clk) begin
		if (reset) begin
			ready_q <= 1'b0;
		end else if (ce) begin
			ready_q <= 1'b1;
		end
	end

	// Pin control select
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_ctrl_q <= `RST_PIN_CONTROL_SELECT;
		end else if (ce && wr_stb && req.addr == `ADDR_PIN_CONTROL_SELECT) begin
			pin_ctrl_q <= req.data;
		end
	end

	assign pin_control = pin_ctrl_q;

	// Interrupt masks
	always_ff @(posedge clk) begin
		if (reset) begin
			in_fail_mask_q <= `RST_IRQ_MASK;
			loop_mask_q    <= `RST_IRQ_MASK;
		end else if (ce && wr_stb) begin
			if (req.addr == `ADDR_INPUT_FAIL_IRQ_MASK) begin
				in_fail_mask_q <= req.data;
			end else if (req.addr == `ADDR_LOOP_IRQ_MASK) begin
				loop_mask_q <= req.data;
			end
		end
	end

	// Monitor fault masks
	always_ff @(posedge clk) begin
		if (reset) begin
			mon_mask_a_q <= `RST_MON_FAULT_MASK;
			mon_mask_b_q <= `RST_MON_FAULT_MASK;
		end else if (ce && wr_stb) begin
			if (req.addr == `ADDR_MON_FAULT_MASK_A) begin
				mon_mask_a_q <= req.data;
			end else if (req.addr == `ADDR_MON_FAULT_MASK_B) begin
				mon_mask_b_q <= req.data;
			end
		end
	end

	assign mon_mask = {mon_mask_b_q[3:0], mon_mask_a_q};

	////////////////////////////////////////////////////////////////////////
	// Clear-on-read strobes for sticky registers
	assign loop_clr   = rd_stb && req.addr == `ADDR_LOOP_IRQ_STATUS;
	assign mon_clr    = {{4{rd_stb && req.addr == `ADDR_MON_FAULT_FLAGS_B}},
	                     {8{rd_stb && req.addr == `ADDR_MON_FAULT_FLAGS_A}}};

	// Sticky loop interrupt bits, a new event wins over the clear
	always_ff @(posedge clk) begin
		if (reset) begin
			loop_isr_q <= `RST_LOOP_IRQ_STATUS;
		end else if (ce) begin
			loop_isr_q <= (loop_isr_q & ~{8{loop_clr}}) | loop_event;
		end
	end

	// Sticky monitor fault flags, a new fault wins over the clear
	always_ff @(posedge clk) begin
		if (reset) begin
			mon_flags_q <= {`RST_NIBBLE, `RST_MON_FAULT_FLAGS};
		end else if (ce) begin
			mon_flags_q <= (mon_flags_q & ~mon_clr) | mon_fail;
		end
	end

	// Per-input failure summary over the selected fault indicators
	for (genvar i = 0; i < 3; i++) begin : g_ref
		assign ref_any_fail[i] = |(mon_flags_q[4*i +: 4] & mon_mask[4*i +: 4]);
	end

	// Input failure interrupt status follows the summary
	always_ff @(posedge clk) begin
		if (reset) begin
			in_fail_isr_q <= `RST_INPUT_FAIL_IRQ_STATUS;
		end else if (ce) begin
			in_fail_isr_q <= {`READ_AS_ZERO_5, ref_any_fail};
		end
	end

	// Detected frequency codes
	always_ff @(posedge clk) begin
		if (reset) begin
			freq_q <= {`RST_NIBBLE, `RST_MEAS_FREQ_CODE};
		end else if (ce) begin
			freq_q <= freq_code;
		end
	end

	// Interrupt output, active low, from enabled status bits
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= |(in_fail_isr_q & in_fail_mask_q) | |(loop_isr_q & loop_mask_q);
		end
	end

	assign irq_n = ~irq_q;

	////////////////////////////////////////////////////////////////////////
	// Read multiplexer
	always_comb begin
		rd_mux = `READ_AS_ZERO;
		if (req.addr == `ADDR_CHIP_IDENTITY_WORD) begin
			rd_mux = {ready_q, CHIP_IDENTITY};
		end else if (req.addr == `ADDR_PIN_CONTROL_SELECT) begin
			rd_mux = pin_ctrl_q;
		end else if (req.addr == `ADDR_INPUT_FAIL_IRQ_STATUS) begin
			rd_mux = in_fail_isr_q;
		end else if (req.addr == `ADDR_LOOP_IRQ_STATUS) begin
			rd_mux = loop_isr_q;
		end else if (req.addr == `ADDR_MON_FAULT_FLAGS_A) begin
			rd_mux = {mon_flags_q.input_clock_one, mon_flags_q.input_clock_zero};
		end else if (req.addr == `ADDR_MON_FAULT_FLAGS_B) begin
			rd_mux = {`UPPER_NIBBLE_ONES, mon_flags_q.input_clock_two};
		end else if (req.addr == `ADDR_INPUT_FAIL_IRQ_MASK) begin
			rd_mux = in_fail_mask_q;
		end else if (req.addr == `ADDR_LOOP_IRQ_MASK) begin
			rd_mux = loop_mask_q;
		end else if (req.addr == `ADDR_MON_FAULT_MASK_A) begin
			rd_mux = mon_mask_a_q;
		end else if (req.addr == `ADDR_MON_FAULT_MASK_B) begin
			rd_mux = mon_mask_b_q;
		end else if (req.addr == `ADDR_MEAS_FREQ_CODE_A) begin
			rd_mux = {freq_q.input_clock_one, freq_q.input_clock_zero};
		end else if (req.addr == `ADDR_MEAS_FREQ_CODE_B) begin
			rd_mux = {`UPPER_NIBBLE_ONES, freq_q.input_clock_two};
		end
	end

	// Read data register handed to the serial port
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_data_q  <= `READ_AS_ZERO;
			rd_valid_q <= 1'b0;
		end else if (ce) begin
			rd_valid_q <= rd_stb;
			if (rd_stb) begin
				rd_data_q <= rd_mux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_ready;
		@(posedge clk) disable iff (reset)
		ce |=> ready_q;
	endproperty
	a_ready: assert property (p_ready) else $error("ready bit not set after reset");

	property p_pin_write;
		@(posedge clk) disable iff (reset)
		ce && wr_stb && req.addr == `ADDR_PIN_CONTROL_SELECT |=> pin_control == $past(req.data);
	endproperty
	a_pin_write: assert property (p_pin_write) else $error("pin control not written");

	property p_reset_values;
		@(posedge clk) disable iff (reset)
		$fell(reset) |-> loop_isr_q == `RST_LOOP_IRQ_STATUS && in_fail_isr_q == `RST_INPUT_FAIL_IRQ_STATUS
			&& pin_ctrl_q == `RST_PIN_CONTROL_SELECT && mon_mask_a_q == `RST_MON_FAULT_MASK;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("wrong reset value");

	property p_loop_sticky;
		@(posedge clk) disable iff (reset)
		ce && !loop_clr |=> (loop_isr_q & $past(loop_isr_q)) == $past(loop_isr_q);
	endproperty
	a_loop_sticky: assert property (p_loop_sticky) else $error("loop status bit lost");

	property p_loop_clear;
		@(posedge clk) disable iff (reset)
		ce && loop_clr |=> loop_isr_q == $past(loop_event);
	endproperty
	a_loop_clear: assert property (p_loop_clear) else $error("loop clear wrong");

	property p_mon_sticky;
		@(posedge clk) disable iff (reset)
		ce && mon_clr == 12'h000 |=> (mon_flags_q & $past(mon_flags_q)) == $past(mon_flags_q);
	endproperty
	a_mon_sticky: assert property (p_mon_sticky) else $error("fault flag lost");

	property p_irq_gate;
		@(posedge clk) disable iff (reset)
		ce && in_fail_mask_q == `RST_IRQ_MASK && loop_mask_q == `RST_IRQ_MASK |=> irq_n;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt raised while masked");

	property p_freq_track;
		@(posedge clk) disable iff (reset)
		ce |=> freq_q == $past(freq_code);
	endproperty
	a_freq_track: assert property (p_freq_track) else $error("frequency code not tracked");

	property p_reserved_read;
		@(posedge clk) disable iff (reset)
		ce && rd_stb && (req.addr == `ADDR_RSVD_04 || req.addr == `ADDR_RSVD_13) |=> rd_data_q == `READ_AS_ZERO;
	endproperty
	a_reserved_read: assert property (p_reserved_read) else $error("reserved read not zero");

	property p_loop_set;
		@(posedge clk) disable iff (reset)
		ce && loop_event != `READ_AS_ZERO |=> (loop_isr_q & $past(loop_event)) == $past(loop_event);
	endproperty
	a_loop_set: assert property (p_loop_set) else $error("loop event not latched");

	property p_loop_ro;
		@(posedge clk) disable iff (reset)
		ce && wr_stb && req.addr == `ADDR_LOOP_IRQ_STATUS |=> loop_isr_q == ($past(loop_isr_q) | $past(loop_event));
	endproperty
	a_loop_ro: assert property (p_loop_ro) else $error("loop status written");

	property p_mon_set;
		@(posedge clk) disable iff (reset)
		ce |=> (mon_flags_q & $past(mon_fail)) == $past(mon_fail);
	endproperty
	a_mon_set: assert property (p_mon_set) else $error("fault not latched");

	property p_mon_clear_a;
		@(posedge clk) disable iff (reset)
		ce && rd_stb && req.addr == `ADDR_MON_FAULT_FLAGS_A |=> mon_flags_q.input_clock_zero == $past(mon_fail.input_clock_zero)
			&& mon_flags_q.input_clock_one == $past(mon_fail.input_clock_one);
	endproperty
	a_mon_clear_a: assert property (p_mon_clear_a) else $error("fault flags not cleared on read");

	property p_irq_mask_write;
		@(posedge clk) disable iff (reset)
		ce && wr_stb && req.addr == `ADDR_INPUT_FAIL_IRQ_MASK |=> in_fail_mask_q == $past(req.data);
	endproperty
	a_irq_mask_write: assert property (p_irq_mask_write) else $error("failure mask not written");

	property p_mon_mask_write;
		@(posedge clk) disable iff (reset)
		ce && wr_stb && req.addr == `ADDR_MON_FAULT_MASK_B |=> mon_mask_b_q == $past(req.data);
	endproperty
	a_mon_mask_write: assert property (p_mon_mask_write) else $error("fault mask not written");

	property p_irq_raise;
		@(posedge clk) disable iff (reset)
		ce && (|(in_fail_isr_q & in_fail_mask_q) || |(loop_isr_q & loop_mask_q)) |=> !irq_n;
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("enabled status raised no interrupt");

	property p_identity_read;
		@(posedge clk) disable iff (reset)
		ce && rd_stb && req.addr == `ADDR_CHIP_IDENTITY_WORD |=> rd_data_q == {1'b1, CHIP_IDENTITY};
	endproperty
	a_identity_read: assert property (p_identity_read) else $error("identity read wrong");

	property p_freq_read;
		@(posedge clk) disable iff (reset)
		ce && rd_stb && req.addr == `ADDR_MEAS_FREQ_CODE_B
			|=> rd_data_q == {`UPPER_NIBBLE_ONES, $past(freq_q.input_clock_two)};
	endproperty
	a_freq_read: assert property (p_freq_read) else $error("frequency code read wrong");

	property p_pin_hold;
		@(posedge clk) disable iff (reset)
		ce && !(wr_stb && req.addr == `ADDR_PIN_CONTROL_SELECT) |=> $stable(pin_control);
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("pin control changed without write");

endmodule

`default_nettype wire

/* File: test/spi_host_model.sv */
// Serial host model: mode 0 frames of a command byte then one data byte.
// Assumes clk is the device clock; pins change on its falling edge only.
`default_nettype none

module spi_host_model (
	// Clock
	input  wire logic                   clk,
	// Serial pins
	output var  sync_regs_pkg::spi_in_s spi_in,
	input  wire logic                   miso
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////
	// Idle pins: clock low and still, select high
	initial begin
		spi_in = 3'b010;
	end

	////////////////////////////////////////////////////////////////////////
	// One access; six clk cycles per half period, above the three allowed
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd, output logic [7:0] rv);
		logic [15:0] sh;
		sh = {rd, a, wd};
		rv = 8'h00;
		@(negedge clk);
		spi_in.cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spi_in.mosi = sh[i];
			repeat (6) @(negedge clk);
			spi_in.sclk = 1'b1;
			repeat (6) @(negedge clk);
			if (i < 8) begin
				rv[i] = miso;
			end
			spi_in.sclk = 1'b0;
		end
		repeat (6) @(negedge clk);
		spi_in.cs_n = 1'b1;
		spi_in.mosi = ~spi_in.mosi; // Released line shows no stale value
		repeat (4) @(negedge clk);
	endtask
endmodule

`default_nettype wire

/* File: test/sync_misc_irq_monitor_regs_test.sv */
// Self-checking bench of the register bank, reached through the host model.
// Assumes the package and constants header are compiled first.
`default_nettype none

module sync_misc_irq_monitor_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] ID = 7'h35; // Arbitrary value

	logic                        clk, reset, ce, miso, miso_oe, irq_n;
	sync_regs_pkg::spi_in_s      spi_in;
	sync_regs_pkg::ref_nibbles_s mon_fail, freq_code;
	logic [7:0]                  loop_event, pin_control, rv;
	int                          miscompares, compares, cycles;

	////////////////////////////////////////////////////////////////////////
	// Design and serial host
	sync_misc_irq_monitor_regs #(.CHIP_IDENTITY(ID)) DUT (
		.clk(clk), .reset(reset), .ce(ce), .spi_in(spi_in), .miso(miso), .miso_oe(miso_oe),
		.mon_fail(mon_fail), .freq_code(freq_code), .loop_event(loop_event),
		.pin_control(pin_control), .irq_n(irq_n));
	spi_host_model host (.clk(clk), .spi_in(spi_in), .miso(miso));

	////////////////////////////////////////////////////////////////////////
	// Clock and hang limit
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		host.xfer(1'b1, a, 8'h00, rv);
		chk($sformatf("reg %h", a), e, rv);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.xfer(1'b0, a, d, rv);
	endtask
	task automatic chk_irq(input logic e);
		repeat (3) @(negedge clk);
		chk("irq_n", {7'h00, e}, {7'h00, irq_n});
	endtask
	task automatic pulse(input logic [7:0] ev, input logic [11:0] mf);
		@(negedge clk);
		loop_event = ev;
		mon_fail = mf;
		@(negedge clk);
		loop_event = 8'h00;
		mon_fail = 12'h000;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Values after reset, sticky clear on read, reserved reads
	task automatic s_reset();
		rd(7'h00, {1'b1, ID});
		rd(7'h01, 8'h00);
		rd(7'h02, 8'h07);
		rd(7'h03, 8'h70);
		rd(7'h03, 8'h00);
		rd(7'h05, 8'hff);
		rd(7'h06, 8'hff);
		rd(7'h06, 8'hf0);
		rd(7'h05, 8'h00);
		rd(7'h02, 8'h00);
		rd(7'h09, 8'h00);
		rd(7'h0a, 8'h00);
		rd(7'h0c, 8'hff);
		rd(7'h0d, 8'hff);
		rd(7'h10, 8'hff);
		rd(7'h11, 8'hff);
		rd(7'h04, 8'h00);
		rd(7'h07, 8'h00);
		rd(7'h08, 8'h00);
		rd(7'h0b, 8'h00);
		rd(7'h0e, 8'h00);
		rd(7'h0f, 8'h00);
		rd(7'h12, 8'h00);
		rd(7'h13, 8'h00);
		chk_irq(1'b1);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Writable registers and refused writes
	task automatic s_rw();
		wr(7'h01, 8'h5a);
		chk("pin_control", 8'h5a, pin_control);
		rd(7'h01, 8'h5a);
		wr(7'h09, 8'ha5);
		rd(7'h09, 8'ha5);
		wr(7'h0a, 8'h3c);
		rd(7'h0a, 8'h3c);
		wr(7'h0c, 8'h0f);
		rd(7'h0c, 8'h0f);
		wr(7'h0d, 8'he1);
		rd(7'h0d, 8'he1);
		wr(7'h00, 8'h00);
		rd(7'h00, {1'b1, ID});
		wr(7'h10, 8'h00);
		rd(7'h10, 8'hff);
		wr(7'h03, 8'h55);
		rd(7'h03, 8'h00);
		rd(7'h04, 8'h00);
		wr(7'h20, 8'h55);
		rd(7'h20, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Sticky events, masks and the interrupt line
	task automatic s_irq();
		wr(7'h09, 8'h02);
		wr(7'h0a, 8'h01);
		wr(7'h0c, 8'hf0);
		pulse(8'h02, 12'h000);
		chk_irq(1'b1);
		rd(7'h03, 8'h02);
		pulse(8'h01, 12'h000);
		chk_irq(1'b0);
		rd(7'h03, 8'h01);
		chk_irq(1'b1);
		pulse(8'h00, 12'h041);
		chk_irq(1'b0);
		rd(7'h02, 8'h02);
		rd(7'h05, 8'h41);
		rd(7'h02, 8'h00);
		chk_irq(1'b1);
		pulse(8'h00, 12'h800);
		rd(7'h02, 8'h00);
		rd(7'h06, 8'hf8);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Live frequency codes and frozen state with enable low
	task automatic s_freq();
		@(negedge clk);
		freq_code = {4'h3, 4'h9, 4'hc};
		rd(7'h10, 8'h9c);
		rd(7'h11, 8'hf3);
		@(negedge clk);
		ce = 1'b0;
		pulse(8'h01, 12'h000);
		@(negedge clk);
		ce = 1'b1;
		rd(7'h03, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Reset in mid-run, output enable while selected
	task automatic s_rerst();
		@(negedge clk);
		reset = 1'b1;
		repeat (3) @(negedge clk);
		reset = 1'b0;
		chk("pin_control", 8'h00, pin_control);
		chk("irq_n", 8'h01, {7'h00, irq_n});
		rd(7'h01, 8'h00);
		rd(7'h09, 8'h00);
		rd(7'h0a, 8'h00);
		rd(7'h0c, 8'hff);
		rd(7'h0d, 8'hff);
		rd(7'h03, 8'h70);
		fork
			wr(7'h01, 8'hc3);
			begin
				repeat (20) @(negedge clk);
				chk("miso_oe", 8'h01, {7'h00, miso_oe});
			end
		join
		chk("miso_oe", 8'h00, {7'h00, miso_oe});
		chk("pin_control", 8'hc3, pin_control);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic complete_run();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		reset = 1'b1;
		ce = 1'b1;
		mon_fail = 12'h000;
		freq_code = 12'hfff;
		loop_event = 8'h00;
		repeat (3) @(negedge clk);
		reset = 1'b0;
		s_reset();
		s_rw();
		s_irq();
		s_freq();
		s_rerst();
		complete_run();
	end
endmodule

`default_nettype wire
